// file: acl_cfg.svh
// timing and framing constants for the audio codec link
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH

`define ACL_MCLK_KHZ        125000
`define ACL_BCLK_KHZ        24000
`define ACL_SAMPLE_KHZ      48
`define ACL_FRAME_BITS      (`ACL_BCLK_KHZ / `ACL_SAMPLE_KHZ)
`define ACL_FRAME_HALVES    (2 * `ACL_FRAME_BITS)
`define ACL_SYNC_MARK_BITS  4
`define ACL_TAG_BITS        4
`define ACL_HDR_BITS        (`ACL_SYNC_MARK_BITS + `ACL_TAG_BITS)
`define ACL_WORD_BITS       16

`endif

// file: acl_pkg.sv
// types shared by the audio codec link
`default_nettype none
package acl_pkg;
   typedef enum logic [0:0] {
      ACL_HOLD,
      ACL_RUN
   } acl_state_t;
   typedef logic [3:0] acl_stream_t;
endpackage
`default_nettype wire

// file: acl_buf2.sv
// two-entry buffer with registered flags and read data
`default_nettype none
module acl_buf2 #(
   parameter int WIDTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] mem [2];
   logic             wr_ptr;
   logic             rd_ptr;
   logic             push;
   logic             pop;

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
      end
      else
      begin
         if (push)
            wr_ptr <= ~wr_ptr;
         if (pop)
            rd_ptr <= ~rd_ptr;
      end

   always_ff @(posedge mclk)
      if (push)
         mem[wr_ptr] <= in_data;

   // flags kept as flops so the ready seen upstream is glitch free
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end
      else if (push && !pop)
      begin
         out_valid <= 1'b1;
         in_ready  <= (wr_ptr == rd_ptr) ? 1'b1 : 1'b0;
      end
      else if (pop && !push)
      begin
         in_ready  <= 1'b1;
         out_valid <= (wr_ptr == rd_ptr) ? 1'b1 : 1'b0;
      end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         out_data <= '0;
      else if (pop || !out_valid || push)
         out_data <= (pop || !out_valid) ? ((out_valid && pop) ? ((wr_ptr != ~rd_ptr) ? mem[~rd_ptr] : in_data)
                                                               : in_data)
                                         : out_data;
endmodule // acl_buf2
`default_nettype wire

// file: acl_link.sv
// audio codec link controller: bit clock, frame sync, serial out and three serial inputs
`include "acl_cfg.svh"
`default_nettype none
module acl_link #(
   parameter int WORD = `ACL_WORD_BITS
) (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  link_enable,
   input  wire acl_pkg::acl_stream_t  stream_number,
   input  wire logic [WORD-1:0]       tx_data,
   input  wire logic                  tx_valid,
   output var  logic                  tx_ready,
   output var  logic [3*WORD-1:0]     rx_data,
   output var  logic [2:0]            rx_valid,
   input  wire logic                  power_good,
   output var  logic                  four_lane_mode,
   output var  logic                  codec_reset_n,
   output var  logic                  link_bit_clock,
   output var  logic                  frame_sync,
   output var  logic                  frame_sync_oe_n,
   input  wire logic                  frame_sync_pin,
   output var  logic                  serial_out_to_codec,
   output var  logic                  serial_out_oe_n,
   input  wire logic                  serial_out_pin,
   input  wire logic [2:0]            serial_in_from_codec
);
   import acl_pkg::*;

   localparam logic [7:0] MCLK_MHZ  = 8'(`ACL_MCLK_KHZ / 1000);
   localparam logic [7:0] HALF_MHZ  = 8'(2 * `ACL_BCLK_KHZ / 1000);
   localparam logic [9:0] LAST_HALF = 10'(`ACL_FRAME_HALVES - 1);
   localparam logic [8:0] MARK_END  = 9'(`ACL_SYNC_MARK_BITS);
   localparam logic [8:0] HDR_END   = 9'(`ACL_HDR_BITS);
   localparam int         CW        = $clog2(WORD + 1);

   acl_state_t       state;
   logic [6:0]       acc;
   logic [7:0]       acc_sum;
   logic             tick;
   logic [9:0]       half;
   logic [9:0]       next_half;
   logic [8:0]       next_bit;
   logic [2:0]       pg_sync;
   logic [1:0]       fs_sync;
   logic [1:0]       so_sync;
   logic [2:0]       sdin_s1;
   logic [2:0]       sdin_s2;
   logic [WORD-1:0]  sh;
   logic [CW-1:0]    bits_left;
   logic [WORD-1:0]  buf_data;
   logic             buf_valid;
   logic             buf_pop;
   logic             in_data_zone;
   logic             rx_take;
   acl_stream_t      frame_tag;

   // fractional divider: 125 MHz cannot divide to 24 MHz by an integer, so edges jitter by one mclk
   assign acc_sum   = {1'b0, acc} + HALF_MHZ;
   assign tick      = (state == ACL_RUN) && (acc_sum >= MCLK_MHZ);
   assign next_half = (half == LAST_HALF) ? 10'h000 : half + 10'h001;
   assign next_bit  = next_half[9:1];
   assign in_data_zone = next_bit >= HDR_END;

   // header level for one bit period: start marker, then the frame's stream tag msb first
   function automatic logic sync_level(logic [8:0] bit_no, acl_stream_t tag);
      logic [8:0] tag_pos;
      tag_pos = HDR_END - 9'h001 - bit_no;
      if (bit_no < MARK_END)
         return 1'b1;
      else if (bit_no < HDR_END)
         return tag[tag_pos[1:0]];
      else
         return 1'b0;
   endfunction

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         state <= ACL_HOLD;
      else
         state <= (link_enable && pg_sync[1]) ? ACL_RUN : ACL_HOLD;

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         codec_reset_n <= 1'b0;
      else
         codec_reset_n <= (state == ACL_RUN);

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         acc <= 7'h00;
      else if (state != ACL_RUN)
         acc <= 7'h00;
      else if (tick)
         acc <= 7'(acc_sum - MCLK_MHZ);
      else
         acc <= acc_sum[6:0];

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         half           <= LAST_HALF;
         link_bit_clock <= 1'b0;
      end
      else if (state != ACL_RUN)
      begin
         half           <= LAST_HALF;
         link_bit_clock <= 1'b0;
      end
      else if (tick)
      begin
         half           <= next_half;
         link_bit_clock <= ~next_half[0];
      end

   // tag held for the whole frame so a change mid-header cannot mix two stream numbers
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         frame_tag <= '0;
      else if (tick && next_half == 10'h000)
         frame_tag <= stream_number;

   // frame marker then stream tag, msb first, both on rising edges
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         frame_sync <= 1'b0;
      else if (state != ACL_RUN)
         frame_sync <= 1'b0;
      else if (tick && !next_half[0])
         frame_sync <= sync_level(next_bit, frame_tag);

   // straps: pins undriven until power good so the pulled levels can be read
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         pg_sync <= 3'h0;
         fs_sync <= 2'h0;
         so_sync <= 2'h0;
      end
      else
      begin
         pg_sync <= {pg_sync[1:0], power_good};
         fs_sync <= {fs_sync[0], frame_sync_pin};
         so_sync <= {so_sync[0], serial_out_pin};
      end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
         four_lane_mode <= 1'b0;
      else if (pg_sync[1] && !pg_sync[2])
         four_lane_mode <= fs_sync[1] && so_sync[1];

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         frame_sync_oe_n <= 1'b1;
         serial_out_oe_n <= 1'b1;
      end
      else
      begin
         frame_sync_oe_n <= ~pg_sync[2];
         serial_out_oe_n <= ~pg_sync[2];
      end

   acl_buf2 #(
      .WIDTH (WORD)
   ) u_txbuf (
      .mclk      (mclk),
      .rst       (rst),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (buf_pop)
   );

   assign buf_pop = tick && in_data_zone && (bits_left == '0) && buf_valid;

   // one new bit every half period gives the double rate output
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         serial_out_to_codec <= 1'b0;
         sh                  <= '0;
         bits_left           <= '0;
      end
      else if (state != ACL_RUN)
      begin
         serial_out_to_codec <= 1'b0;
         bits_left           <= '0;
      end
      else if (tick)
      begin
         if (!in_data_zone)
            serial_out_to_codec <= 1'b0;
         else if (bits_left != '0)
         begin
            serial_out_to_codec <= sh[WORD-1];
            sh                  <= sh << 1;
            bits_left           <= bits_left - CW'(1);
         end
         else if (buf_valid)
         begin
            serial_out_to_codec <= buf_data[WORD-1];
            sh                  <= buf_data << 1;
            bits_left           <= CW'(WORD - 1);
         end
         else
            serial_out_to_codec <= 1'b0;
      end

   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         sdin_s1 <= 3'h0;
         sdin_s2 <= 3'h0;
      end
      else
      begin
         sdin_s1 <= serial_in_from_codec;
         sdin_s2 <= sdin_s1;
      end

   // sample one mclk after the falling edge: a half period may be only two mclk,
   // shorter than the input synchroniser's lag behind the codec's rising-edge change
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         rx_take <= 1'b0;
      else
         rx_take <= tick && next_half[0] && in_data_zone;

   // only the current link type is framed here; no legacy slot layout
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_rx
         logic [WORD-1:0] rsh;
         logic [CW-1:0]   rcnt;

         always_ff @(posedge mclk or posedge rst)
            if (rst)
            begin
               rsh                       <= '0;
               rcnt                      <= '0;
               rx_valid[g]               <= 1'b0;
               rx_data[g*WORD +: WORD]   <= '0;
            end
            else
            begin
               rx_valid[g] <= 1'b0;
               if (state != ACL_RUN || (tick && next_half == 10'h000))
                  rcnt <= '0;
               else if (rx_take)
               begin
                  // codec bit has cleared both synchroniser stages by now
                  rsh <= {rsh[WORD-2:0], sdin_s2[g]};
                  if (rcnt == CW'(WORD - 1))
                  begin
                     rcnt                    <= '0;
                     rx_valid[g]             <= 1'b1;
                     rx_data[g*WORD +: WORD] <= {rsh[WORD-2:0], sdin_s2[g]};
                  end
                  else
                     rcnt <= rcnt + CW'(1);
               end
            end
      end
   endgenerate
endmodule // acl_link
`default_nettype wire

// file: acl_link_chk.sv
// assertion checker on the codec link ports
`default_nettype none
module acl_link_chk #(
   parameter int WORD = 16
) (
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              link_enable,
   input wire logic              power_good,
   input wire logic              four_lane_mode,
   input wire logic              codec_reset_n,
   input wire logic              link_bit_clock,
   input wire logic              frame_sync,
   input wire logic              frame_sync_oe_n,
   input wire logic              serial_out_to_codec,
   input wire logic              serial_out_oe_n,
   input wire logic [3*WORD-1:0] rx_data,
   input wire logic [2:0]        rx_valid
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_enable_idle: assert property (!link_enable [*3] |-> !codec_reset_n && !link_bit_clock && !frame_sync)
      else $error("link active while disabled");
   chk_power_idle: assert property (!power_good [*5] |-> !codec_reset_n && !serial_out_to_codec)
      else $error("link active before power good");
   chk_half_len: assert property ($changed(link_bit_clock) |=> $stable(link_bit_clock) ##[1:2] $changed(link_bit_clock))
      else $error("bit clock half period not 2 or 3 cycles");
   chk_sync_edge: assert property ($changed(frame_sync) |-> $rose(link_bit_clock))
      else $error("frame sync moved off a rising bit clock");
   chk_dout_edge: assert property ($changed(serial_out_to_codec) |-> $changed(link_bit_clock))
      else $error("serial out moved off a bit clock edge");
   chk_oe_hold: assert property (!power_good [*5] |-> frame_sync_oe_n)
      else $error("pins driven before power good");
   chk_oe_pair: assert property (serial_out_oe_n == frame_sync_oe_n)
      else $error("pin enables differ");
   chk_oe_release: assert property ($rose(power_good) |-> ##[1:6] !frame_sync_oe_n)
      else $error("pins not driven after power good");
   chk_lane_hold: assert property ($changed(four_lane_mode) |-> $past(frame_sync_oe_n))
      else $error("lane mode changed while pins driven");
   chk_rx_gap: assert property (rx_valid[0] |=> !rx_valid[0] [*8])
      else $error("input words too close");
   chk_rx_lines: assert property ($changed(rx_data[2*WORD+:WORD]) |-> rx_valid[2])
      else $error("line two data moved without valid");
endmodule // acl_link_chk

bind acl_link acl_link_chk #(.WORD(WORD)) u_chk (.mclk, .rst, .link_enable, .power_good, .four_lane_mode,
   .codec_reset_n, .link_bit_clock, .frame_sync, .frame_sync_oe_n, .serial_out_to_codec, .serial_out_oe_n,
   .rx_data, .rx_valid);
`default_nettype wire

// file: acl_codec_model.sv
// behavioural model of three codecs on the serial inputs
`default_nettype none
module acl_codec_model (
   input  wire logic        link_bit_clock,
   input  wire logic        frame_sync,
   input  wire logic        codec_reset_n,
   input  wire logic [47:0] base,
   output var  logic [2:0]  sdi = '0,
   output var  logic        note_stb = 1'b0,
   output var  logic [47:0] note_word
);
   timeunit 1ns;
   timeprecision 1ps;
   int          bp = 500;
   int          fr;
   logic        pfs = 1'b0;
   logic [15:0] w;
   // one change per bit period, just after the rise, so the host sees a whole period
   always @(posedge link_bit_clock or negedge codec_reset_n)
      if (!codec_reset_n)
      begin
         bp = 500;
         pfs = 1'b0;
         note_stb = 1'b0;
      end
      else
      begin
         #1;
         if (frame_sync && !pfs && bp >= 8)
         begin
            bp = 0;
            fr++;
         end
         else
            bp++;
         pfs = frame_sync;
         if (bp >= 8 && bp < 488)
            for (int g = 0; g < 3; g++)
            begin
               w = base[g*16+:16] + 16'(fr * 32 + (bp - 8) / 16);
               sdi[g] = w[15 - (bp - 8) % 16];
               note_word[g*16+:16] = w;
            end
         else
            sdi = ~sdi; // outside words the line toggles, never a stale bit
         // strobe last, so the word it announces is already in place
         note_stb = bp >= 8 && bp < 488 && (bp - 8) % 16 == 15;
      end
endmodule // acl_codec_model
`default_nettype wire

// file: tb_top.sv
// testbench for the audio codec link
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import acl_pkg::*;
   logic        mclk = 0, rst = 1, link_enable = 0, power_good = 0, tx_valid = 0;
   logic        tx_ready, four_lane_mode, codec_reset_n, link_bit_clock, frame_sync;
   logic        frame_sync_oe_n, serial_out_to_codec, serial_out_oe_n, note_stb, ok;
   logic        pb, pfs, started, locked;
   acl_stream_t stream_number = '0;
   logic [15:0] tx_data = '0, sh;
   logic [47:0] rx_data, note_word, base = '0;
   logic [2:0]  rx_valid, sdi;
   logic [1:0]  strap = '1;
   int          errors, num_checks, cyc, h, cnt, fst;
   logic [15:0] txq[$], rxq[3][$];
   // straps only read while the pins float
   wire logic   frame_sync_pin = frame_sync_oe_n ? strap[1] : frame_sync;
   wire logic   serial_out_pin = serial_out_oe_n ? strap[0] : serial_out_to_codec;

   initial forever #4 mclk = ~mclk;

   acl_link dut (.mclk, .rst, .link_enable, .stream_number, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
      .power_good, .four_lane_mode, .codec_reset_n, .link_bit_clock, .frame_sync, .frame_sync_oe_n, .frame_sync_pin,
      .serial_out_to_codec, .serial_out_oe_n, .serial_out_pin, .serial_in_from_codec(sdi));
   acl_codec_model mdl (.link_bit_clock, .frame_sync, .codec_reset_n, .base, .sdi, .note_stb, .note_word);

   task automatic chk_bit(string n, logic e, logic g);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s exp %b got %b", n, e, g);
      end
   endtask

   task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic final_report;
      if (errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // entered at a falling edge; leaves valid up for the next word
   task automatic send(logic [15:0] d);
      tx_data = d;
      tx_valid = 1'b1;
      ok = 1'b0;
      while (!ok)
      begin
         ok = tx_ready;
         @(negedge mclk);
      end
      txq.push_back(d);
   endtask

   always @(posedge note_stb)
      for (int g = 0; g < 3; g++)
         rxq[g].push_back(note_word[g*16+:16]);

   always @(negedge mclk)
   begin
      cyc++;
      if (cyc > 40000)
      begin
         errors++;
         final_report();
      end
      for (int g = 0; g < 3; g++)
         if (rx_valid[g] === 1'b1)
         begin
            if (rxq[g].size() == 0)
               chk_bit("rx_note", 1'b1, 1'b0);
            else
               chk_word("rx_word", rxq[g].pop_front(), rx_data[g*16+:16]);
         end
      if (codec_reset_n !== 1'b1)
      begin
         locked = 0;
         h = 0;
         cnt = 0;
         started = 0;
         pb = 0;
         pfs = 0;
      end
      else if (link_bit_clock !== pb)
      begin
         pb = link_bit_clock;
         if (pb && frame_sync && !pfs && (h >= 16 || !locked))
         begin
            if (locked)
               chk_bit("frame_len", 1'b1, h == 999 && cyc - fst inside {[2604:2605]});
            locked = 1;
            fst = cyc;
            h = 0;
         end
         else
            h++;
         if (pb)
         begin
            if (locked)
               chk_bit("frame_sync", h < 8 ? 1'b1 : h < 16 ? stream_number[7 - h / 2] : 1'b0, frame_sync);
            pfs = frame_sync;
         end
         // idle halves carry zeros, so a word is only recognised by its leading one
         if (locked && h >= 16 && txq.size() > 0 && (started || serial_out_to_codec))
         begin
            started = 1;
            sh = {sh[14:0], serial_out_to_codec};
            cnt++;
            if (cnt == 16)
            begin
               chk_word("tx_word", txq.pop_front(), sh);
               cnt = 0;
               started = txq.size() > 0;
            end
         end
      end
   end

   initial
   begin
      void'($urandom(73068));
      for (int i = 0; i < 2; i++)
      begin
         @(negedge mclk);
         rst = 1'b1;
         power_good = 1'b0;
         link_enable = 1'b0;
         strap = i ? 2'($urandom % 3) : 2'b11;
         stream_number = 4'($urandom);
         base = 48'({$urandom, $urandom});
         repeat (5) @(negedge mclk);
         txq.delete();
         for (int g = 0; g < 3; g++)
            rxq[g].delete();
         rst = 1'b0;
         send(16'($urandom) | 16'h8000);
         send(16'($urandom));
         tx_valid = 1'b0;
         repeat (3) @(negedge mclk);
         chk_bit("tx_ready", 1'b0, tx_ready);
         chk_bit("codec_reset_n", 1'b0, codec_reset_n);
         chk_bit("oe_n", 1'b1, frame_sync_oe_n);
         power_good = 1'b1;
         repeat (20) @(negedge mclk);
         chk_bit("four_lane", &strap, four_lane_mode);
         chk_bit("oe_n", 1'b0, serial_out_oe_n);
         chk_bit("codec_reset_n", 1'b0, codec_reset_n);
         link_enable = 1'b1;
         repeat (10) @(negedge mclk);
         chk_bit("codec_reset_n", 1'b1, codec_reset_n);
         repeat (100) send(16'($urandom));
         tx_valid = 1'b0;
         repeat (3000) @(negedge mclk);
         chk_bit("tx_drained", 1'b1, txq.size() == 0);
      end
      final_report();
   end
endmodule // tb_top
`default_nettype wire
